//--- bench/arh_host_model.sv
`timescale 1ns/1ps
module arh_host_model
    import arh_pkg::*;
(
    input  wire logic                clk_in,
    input  wire logic                sdata_in,
    output logic                     sclk_out,
    output logic [RESULT_W-1:0]      word_out
);
    initial
    begin
        sclk_out = 1'b0;
        word_out = '0;
    end

    // Bit is taken before its shift edge; clock rests at idle between reads
    task automatic read(input int n, input logic idle);
        int i;
        for (i = 0; i < n; i++)
        begin
            repeat (4) @(negedge clk_in);
            word_out = {word_out[RESULT_W-2:0], sdata_in};
            sclk_out = ~idle;
            repeat (4) @(negedge clk_in);
            sclk_out = idle;
        end
    endtask
endmodule // arh_host_model

//--- bench/testbench.sv
`timescale 1ns/1ps
module testbench
    import arh_pkg::*;
;
    logic mclk_in, nrst_in, reset_in, convert_start_n_in, cs_n_in, rd_n_in;
    logic word_select_lo_in, word_select_hi_in, coding_select_in;
    logic clock_source_sel_in, clock_invert_in, frame_invert_in;
    logic read_during_convert_in, busy_out, serial_result_out, serial_oe_out;
    logic serial_result_clock_out, serial_clock_oe_out, frame_out;
    logic read_overrun_flag_out, sclk, rerr, bad, pc;
    logic [1:0]  mode_in, clock_divider_sel_in;
    logic [17:0] result_in, data_out, data_oe_out, mw, hw, cw, ex, m;
    logic [17:0] host_word;
    int          failures, num_checks, mn, hc, hh, c, k, d, i;

    arh_port u_arh_port (.mclk_in, .nrst_in, .reset_in, .convert_start_n_in,
        .cs_n_in, .rd_n_in, .mode_in, .word_select_lo_in, .word_select_hi_in,
        .coding_select_in, .clock_source_sel_in, .clock_invert_in,
        .frame_invert_in, .read_during_convert_in, .clock_divider_sel_in,
        .serial_result_clock_in(sclk), .result_in, .data_out, .data_oe_out,
        .busy_out, .serial_result_out, .serial_oe_out,
        .serial_result_clock_out, .serial_clock_oe_out, .frame_out,
        .read_overrun_flag_out);

    arh_host_model u_arh_host_model (.clk_in(mclk_in),
        .sdata_in(serial_result_out), .sclk_out(sclk), .word_out(host_word));

    initial
    begin
        mclk_in = 1'b0;
        forever #20 mclk_in = ~mclk_in;
    end

    ////////////////////////////////////////////////////////////////////////
    // Generated serial stream, clock high time, frame and error watch
    always @(posedge mclk_in)
    begin
        pc <= serial_result_clock_out;
        hc <= serial_result_clock_out ? hc + 1 : 0;
        if (pc && !serial_result_clock_out)
            hh <= hc;
        if (serial_result_clock_out && !pc && frame_out)
        begin
            mw <= {mw[16:0], serial_result_out};
            mn <= mn + 1;
        end
        if (frame_out && !frame_invert_in && !busy_out
            && !read_during_convert_in)
            bad <= 1'b1;
        if (read_overrun_flag_out)
            rerr <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic test_done;
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic wait_busy(input logic lvl);
        int j;
        for (j = 0; j < 500 && busy_out !== lvl; j++)
            @(negedge mclk_in);
        if (busy_out !== lvl)
        begin
            failures++;
            test_done;
        end
    endtask

    // Starts one conversion; optionally checks the old word while busy
    task automatic conv(input logic [17:0] v, input bit mid);
        @(negedge mclk_in);
        result_in = v;
        convert_start_n_in = 1'b0;
        @(negedge mclk_in);
        convert_start_n_in = 1'b1;
        wait_busy(1'b1);
        if (mid)
            chk(data_out, hw);
        wait_busy(1'b0);
        repeat (2) @(negedge mclk_in);
    endtask

    initial
    begin
        {nrst_in, reset_in, word_select_lo_in, word_select_hi_in} = 4'h0;
        {clock_source_sel_in, clock_invert_in, frame_invert_in} = 3'h0;
        {read_during_convert_in, cs_n_in, rd_n_in} = 3'h0;
        {convert_start_n_in, coding_select_in} = 2'h3;
        mode_in = ARH_MODE_P18;
        clock_divider_sel_in = 2'h0;
        result_in = 18'h00000;
        {failures, num_checks, mn, hc, hh} = '0;
        {mw, rerr, bad, pc} = '0;
        repeat (4) @(negedge mclk_in);
        nrst_in = 1'b1;
        repeat (3) @(negedge mclk_in);
        chk(data_out, 18'h00000);
        coding_select_in = 1'b0;
        hw = 18'h2d5a3;
        conv(hw, 0);
        chk(data_out, hw);
        chk(data_oe_out, 18'h3ffff);
        conv(18'h1c3e5, 1);
        hw = 18'h1c3e5;
        for (c = 0; c < 2; c++)
            for (k = 0; k < 5; k++)
            begin
                @(negedge mclk_in);
                coding_select_in = c[0];
                mode_in = (k < 2) ? ARH_MODE_P16 : ARH_MODE_P8;
                {word_select_hi_in, word_select_lo_in} = 2'((k < 2) ? k : k - 2);
                repeat (2) @(negedge mclk_in);
                cw = {hw[17] ^ ~c[0], hw[16:0]};
                ex = (k == 0) ? 18'(cw[17:2]) : (k == 1) ? {cw[1:0], 14'h0}
                   : (k == 2) ? 18'(cw[17:10]) : (k == 3) ? 18'(cw[9:2])
                   : 18'({cw[1:0], 6'h0});
                m = (k < 2) ? 18'h0ffff : 18'h000ff;
                chk(data_out & m, ex);
                chk(data_oe_out & m, m);
            end
        mode_in = ARH_MODE_P18;
        cs_n_in = 1'b1;
        repeat (2) @(negedge mclk_in);
        chk(data_oe_out, 18'h00000);
        {cs_n_in, rd_n_in} = 2'h1;
        repeat (2) @(negedge mclk_in);
        chk(data_oe_out, 18'h00000);
        {rd_n_in, reset_in} = 2'h1;
        repeat (3) @(negedge mclk_in);
        chk(data_oe_out, 18'h00000);
        reset_in = 1'b0;
        repeat (3) @(negedge mclk_in);
        chk(data_out, 18'h00000);
        ////////////////////////////////////////////////////////////////////
        // Host clocked serial reads
        mode_in = ARH_MODE_SER;
        {clock_source_sel_in, coding_select_in} = 2'h3;
        conv(18'h3a5c7, 0);
        cs_n_in = 1'b1;
        u_arh_host_model.read(3, 1'b0);
        // Let the last ignored clock fall pass before selecting
        @(negedge mclk_in);
        cs_n_in = 1'b0;
        u_arh_host_model.read(18, 1'b0);
        chk(host_word, 18'h3a5c7);
        clock_invert_in = 1'b1;
        u_arh_host_model.sclk_out = 1'b1;
        conv(18'h0f0f3, 0);
        u_arh_host_model.read(18, 1'b1);
        chk(host_word, 18'h0f0f3);
        conv(18'h25555, 0);
        u_arh_host_model.read(5, 1'b1);
        chk(host_word & 18'h0001f, 18'h00012);
        chk(18'(rerr), 18'h00000);
        conv(18'h00001, 0);
        chk(18'(rerr), 18'h00001);
        ////////////////////////////////////////////////////////////////////
        // Device clocked serial output
        clock_source_sel_in = 1'b0;
        @(negedge mclk_in);
        {clock_invert_in, frame_invert_in} = 2'h3;
        u_arh_host_model.sclk_out = 1'b0;
        repeat (3) @(negedge mclk_in);
        chk(18'({frame_out, serial_result_clock_out}), 18'h00003);
        {clock_invert_in, frame_invert_in, coding_select_in} = 3'h0;
        repeat (3) @(negedge mclk_in);
        // Frame output lags the invert input by one cycle
        bad = 1'b0;
        for (d = 0; d < 4; d++)
        begin
            clock_divider_sel_in = d[1:0];
            mn = 0;
            hw = 18'h2b6d9 ^ 18'(d << 3);
            conv(hw, 0);
            chk(mw, hw ^ 18'h20000);
            chk(18'(mn), 18'h00012);
            chk(18'(hh), 18'(1 << d));
        end
        chk(18'(bad), 18'h00000);
        read_during_convert_in = 1'b1;
        mn = 0;
        conv(18'h11111, 0);
        for (i = 0; i < 200 && mn < 18; i++)
            @(negedge mclk_in);
        chk(18'(mn), 18'h00012);
        chk(mw, hw ^ 18'h20000);
        chk(18'(hh), 18'(SLOW_HALF));
        test_done;
    end
endmodule // testbench

//--- design/arh_pair_buf.sv
`timescale 1ns/1ps
module arh_pair_buf
    import arh_pkg::*;
#(
    parameter int W = 18
)(
    input  wire logic         clk_in,
    input  wire logic         rst_n_in,
    input  wire logic         flush_in,
    input  wire logic         in_valid_in,
    output logic              in_ready_out,
    input  wire logic [W-1:0] in_data_in,
    output logic              out_valid_out,
    input  wire logic         out_ready_in,
    output logic [W-1:0]      out_data_out
);

    logic [W-1:0] d0_reg;
    logic [W-1:0] d0_next;
    logic [W-1:0] d1_reg;
    logic [W-1:0] d1_next;
    logic [1:0]   cnt_reg;
    logic [1:0]   cnt_next;
    logic         push;
    logic         pop;

    assign in_ready_out  = (cnt_reg != 2'h2);
    assign out_valid_out = (cnt_reg != 2'h0);
    assign out_data_out  = d0_reg;
    assign push          = in_valid_in && in_ready_out;
    assign pop           = out_valid_out && out_ready_in;

    always_comb
    begin
        d0_next  = d0_reg;
        d1_next  = d1_reg;
        cnt_next = cnt_reg;
        if (flush_in)
        begin
            cnt_next = 2'h0;
        end
        else
        begin
            if (pop)
            begin
                d0_next  = d1_reg;
                cnt_next = cnt_next - 2'h1;
            end
            if (push)
            begin
                if (cnt_next == 2'h0)
                    d0_next = in_data_in;
                else
                    d1_next = in_data_in;
                cnt_next = cnt_next + 2'h1;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            d0_reg  <= '0;
            d1_reg  <= '0;
            cnt_reg <= 2'h0;
        end
        else
        begin
            d0_reg  <= d0_next;
            d1_reg  <= d1_next;
            cnt_reg <= cnt_next;
        end
    end

endmodule // arh_pair_buf

//--- design/arh_port.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Outputs float unless select and read low
// - Reset rise aborts conversion, floats data bus
// - Reset fall clears state and output data
// - Select 0/1/2 gives 18/16/8-bit bus
// - Master parallel: bus driven with each result
// - 18-bit bus always straight binary
// - Word selects pick two words or three bytes
// - Coding input picks twos complement elsewhere
// - Select 3 gives serial port on data pins
// - Serial result MSB first, 18 clocks
// - Serial mode configuration taken directly from input pins
// - Internal clock source: device makes clock, frame
// - Invert inputs flip clock and frame polarity
// - Read during convert: previous result, two periods
// - Read after convert: busy until bits sent
// - Read after convert: divider sets clock period
// - External clock shifts only when selected, read
// - External clock may idle high or low
// - Convert start fall begins conversion; reset rise or nrst_in low aborts it
// - Incomplete slave read ends in error pulse
module arh_port
    import arh_pkg::*;
(
    input  wire logic        mclk_in,
    input  wire logic        nrst_in,
    input  wire logic        reset_in,
    input  wire logic        convert_start_n_in,
    input  wire logic        cs_n_in,
    input  wire logic        rd_n_in,
    input  wire logic [1:0]  mode_in,
    input  wire logic        word_select_lo_in,
    input  wire logic        word_select_hi_in,
    input  wire logic        coding_select_in,
    input  wire logic        clock_source_sel_in,
    input  wire logic        clock_invert_in,
    input  wire logic        frame_invert_in,
    input  wire logic        read_during_convert_in,
    input  wire logic [1:0]  clock_divider_sel_in,
    input  wire logic        serial_result_clock_in,
    input  wire logic [17:0] result_in,
    output logic      [17:0] data_out,
    output logic      [17:0] data_oe_out,
    output logic             busy_out,
    output logic             serial_result_out,
    output logic             serial_oe_out,
    output logic             serial_result_clock_out,
    output logic             serial_clock_oe_out,
    output logic             frame_out,
    output logic             read_overrun_flag_out
);

    ////////////////////////////////////////////////////////////////////////
    // Reset release, input history

    logic [1:0]  rst_sync_reg;
    logic        rst_n;
    logic        cnv_prev_reg;
    logic        pin_prev_reg;
    logic        sclk_prev_reg;
    arh_cfg_s    cfg;

    assign rst_n = rst_sync_reg[1];

    always_ff @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            rst_sync_reg <= 2'h0;
        else
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end

    always_comb
    begin
        cfg.mode    = mode_in;
        cfg.coding  = coding_select_in;
        cfg.ext_clk = clock_source_sel_in;
        cfg.clk_inv = clock_invert_in;
        cfg.frm_inv = frame_invert_in;
        cfg.read_during_convert     = read_during_convert_in;
        cfg.div     = clock_divider_sel_in;
    end

    always_ff @(posedge mclk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnv_prev_reg  <= 1'b1;
            pin_prev_reg  <= 1'b0;
            sclk_prev_reg <= 1'b0;
        end
        else
        begin
            cnv_prev_reg  <= convert_start_n_in;
            pin_prev_reg  <= reset_in;
            sclk_prev_reg <= serial_result_clock_in ^ cfg.clk_inv;
        end
    end

    logic rd_en;
    logic serial;
    logic master;
    logic slave;
    logic cnv_fall;
    logic pin_fall;
    logic slave_fall;

    assign rd_en      = !cs_n_in && !rd_n_in;
    assign serial     = (cfg.mode == ARH_MODE_SER);
    assign master     = serial && !cfg.ext_clk;
    assign slave      = serial && cfg.ext_clk;
    assign cnv_fall   = cnv_prev_reg && !convert_start_n_in;
    assign pin_fall   = pin_prev_reg && !reset_in;
    assign slave_fall = sclk_prev_reg &&
                        !(serial_result_clock_in ^ cfg.clk_inv);

    function automatic logic [17:0] code_word(input logic [17:0] w,
                                              input logic [1:0]  m,
                                              input logic        sb);
        if (m == ARH_MODE_P18 || sb)
            code_word = w;
        else
            code_word = {~w[17], w[16:0]};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Conversion sequencer

    arh_state_e  st_reg;
    arh_state_e  st_next;
    logic [15:0] cnt_reg;
    logic [15:0] cnt_next;
    logic        busy_reg;
    logic        busy_next;
    logic        ovr_reg;
    logic        ovr_next;
    logic        conv_end;
    logic        buf_in_ready;
    logic        buf_valid;
    logic [17:0] buf_data;
    logic        act_reg;
    logic [4:0]  bits_reg;
    logic        tx_done;
    logic        pop;

    assign conv_end = (st_reg == ARH_CONV) && (cnt_reg == CONV_LAST);

    always_comb
    begin
        st_next  = st_reg;
        cnt_next = cnt_reg;
        ovr_next = 1'b0;
        if (reset_in)
        begin
            st_next  = ARH_IDLE;
            cnt_next = CNT_RST;
        end
        else
        begin
            case (st_reg)
                ARH_IDLE:
                begin
                    if (cnv_fall && buf_in_ready)
                    begin
                        st_next  = ARH_CONV;
                        cnt_next = CNT_RST;
                    end
                end
                ARH_CONV:
                begin
                    if (conv_end)
                    begin
                        st_next  = (master && !cfg.read_during_convert) ? ARH_SEND
                                                        : ARH_IDLE;
                        cnt_next = CNT_RST;
                        ovr_next = slave && bits_reg != BITS_RST &&
                                   bits_reg < ALL_BITS;
                    end
                    else
                        cnt_next = cnt_reg + 16'h0001;
                end
                ARH_SEND:
                begin
                    if (tx_done)
                        st_next = ARH_IDLE;
                end
                default:
                    st_next = ARH_IDLE;
            endcase
        end
        busy_next = (st_next != ARH_IDLE);
    end

    always_ff @(posedge mclk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_reg   <= ARH_IDLE;
            cnt_reg  <= CNT_RST;
            busy_reg <= 1'b0;
            ovr_reg  <= 1'b0;
        end
        else
        begin
            st_reg   <= st_next;
            cnt_reg  <= cnt_next;
            busy_reg <= busy_next;
            ovr_reg  <= ovr_next;
        end
    end

    // Two results may wait here while a serial transfer is still running
    arh_pair_buf #(
        .W (RESULT_W)
    ) u_buf (
        .clk_in        (mclk_in),
        .rst_n_in      (rst_n),
        .flush_in      (reset_in),
        .in_valid_in   (conv_end),
        .in_ready_out  (buf_in_ready),
        .in_data_in    (result_in),
        .out_valid_out (buf_valid),
        .out_ready_in  (!act_reg),
        .out_data_out  (buf_data)
    );

    assign pop = buf_valid && !act_reg && !reset_in;

    ////////////////////////////////////////////////////////////////////////
    // Result word and serial shifter

    logic [17:0] out_reg;
    logic [17:0] out_next;
    logic [17:0] sh_reg;
    logic [17:0] sh_next;
    logic [4:0]  bits_next;
    logic        act_next;
    logic [7:0]  div_reg;
    logic [7:0]  div_next;
    logic        lvl_reg;
    logic        lvl_next;
    logic [7:0]  half;

    always_comb
    begin
        out_next  = out_reg;
        sh_next   = sh_reg;
        bits_next = bits_reg;
        act_next  = act_reg;
        div_next  = div_reg;
        lvl_next  = lvl_reg;
        tx_done   = 1'b0;
        if (cfg.read_during_convert)
            half = (bits_reg < FAST_BITS) ? FAST_HALF : SLOW_HALF;
        else
            half = BASE_HALF << cfg.div;
        if (pin_fall)
        begin
            out_next  = WORD_RST;
            sh_next   = WORD_RST;
            bits_next = BITS_RST;
            act_next  = 1'b0;
            lvl_next  = 1'b0;
        end
        else if (reset_in)
        begin
            act_next = 1'b0;
            lvl_next = 1'b0;
        end
        else if (act_reg)
        begin
            if (div_reg == half - 8'h01)
            begin
                div_next = DIV_RST;
                lvl_next = !lvl_reg;
                if (lvl_reg)
                begin
                    sh_next   = {sh_reg[16:0], 1'b0};
                    bits_next = bits_reg + 5'h01;
                    if (bits_reg == LAST_BIT)
                    begin
                        act_next = 1'b0;
                        tx_done  = 1'b1;
                    end
                end
            end
            else
                div_next = div_reg + 8'h01;
        end
        else if (pop)
        begin
            out_next  = buf_data;
            sh_next   = code_word(buf_data, cfg.mode, cfg.coding);
            bits_next = BITS_RST;
            if (master && !cfg.read_during_convert)
            begin
                act_next = 1'b1;
                div_next = DIV_RST;
                lvl_next = 1'b0;
            end
        end
        else if (master && cfg.read_during_convert && st_reg == ARH_IDLE &&
                 cnv_fall && buf_in_ready)
        begin
            sh_next   = code_word(out_reg, cfg.mode, cfg.coding);
            bits_next = BITS_RST;
            act_next  = 1'b1;
            div_next  = DIV_RST;
            lvl_next  = 1'b0;
        end
        else if (slave && rd_en && slave_fall && bits_reg < ALL_BITS)
        begin
            sh_next   = {sh_reg[16:0], 1'b0};
            bits_next = bits_reg + 5'h01;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            out_reg  <= WORD_RST;
            sh_reg   <= WORD_RST;
            bits_reg <= BITS_RST;
            act_reg  <= 1'b0;
            div_reg  <= DIV_RST;
            lvl_reg  <= 1'b0;
        end
        else
        begin
            out_reg  <= out_next;
            sh_reg   <= sh_next;
            bits_reg <= bits_next;
            act_reg  <= act_next;
            div_reg  <= div_next;
            lvl_reg  <= lvl_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin drivers

    logic [17:0] data_next;
    logic [17:0] oe_next;
    logic [17:0] w;
    logic        oe_all;

    always_comb
    begin
        w         = code_word(out_reg, cfg.mode, cfg.coding);
        oe_all    = rd_en && !reset_in;
        data_next = WORD_RST;
        oe_next   = WORD_RST;
        case (cfg.mode)
            ARH_MODE_P18:
            begin
                data_next = out_reg;
                oe_next   = {18{oe_all}};
            end
            ARH_MODE_P16:
            begin
                data_next[15:0] = word_select_lo_in ? {w[1:0], 14'h0000}
                                                    : w[17:2];
                oe_next[15:0]   = {16{oe_all}};
            end
            ARH_MODE_P8:
            begin
                case ({word_select_hi_in, word_select_lo_in})
                    2'h0:    data_next[7:0] = w[17:10];
                    2'h1:    data_next[7:0] = w[9:2];
                    default: data_next[7:0] = {w[1:0], 6'h00};
                endcase
                oe_next[7:0] = {8{oe_all}};
            end
            default:
            begin
                data_next = WORD_RST;
                oe_next   = WORD_RST;
            end
        endcase
    end

    always_ff @(posedge mclk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            data_out                <= WORD_RST;
            data_oe_out             <= WORD_RST;
            busy_out                <= 1'b0;
            serial_result_out       <= 1'b0;
            serial_oe_out           <= 1'b0;
            serial_result_clock_out <= 1'b0;
            serial_clock_oe_out     <= 1'b0;
            frame_out               <= 1'b0;
            read_overrun_flag_out   <= 1'b0;
        end
        else
        begin
            data_out                <= data_next;
            data_oe_out             <= oe_next;
            busy_out                <= busy_reg;
            serial_result_out       <= sh_reg[17];
            serial_oe_out           <= oe_all && serial;
            serial_result_clock_out <= lvl_reg ^ cfg.clk_inv;
            serial_clock_oe_out     <= oe_all && master;
            frame_out               <= act_reg ^ cfg.frm_inv;
            read_overrun_flag_out   <= ovr_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n);

    sequence master_rac_end;
        conv_end && master && !cfg.read_during_convert && !reset_in;
    endsequence

    sequence send_then_busy;
        (st_reg == ARH_SEND) ##1 busy_reg ##1 busy_out;
    endsequence

    out_float_a: assert property ((cs_n_in || rd_n_in) |=>
        (data_oe_out == WORD_RST && !serial_oe_out))
        else $error("outputs driven without select and read");

    reset_abort_a: assert property ($rose(reset_in) |=>
        (st_reg == ARH_IDLE && !busy_reg && data_oe_out == WORD_RST))
        else $error("reset rise did not abort");

    reset_clear_a: assert property ($fell(reset_in) |=>
        (out_reg == WORD_RST && bits_reg == BITS_RST))
        else $error("reset fall did not clear result");

    wide_straight_a: assert property ((cfg.mode == ARH_MODE_P18 &&
        $stable(out_reg)) |=> (data_out == $past(out_reg)))
        else $error("18-bit bus not straight binary");

    byte_pick_a: assert property ((cfg.mode == ARH_MODE_P8 &&
        !word_select_hi_in && word_select_lo_in && $stable(out_reg))
        |=> (data_out[7:0] == $past(w[9:2])))
        else $error("middle byte wrong");

    twos_msb_a: assert property ((cfg.mode == ARH_MODE_P16 &&
        !cfg.coding && !word_select_lo_in && $stable(out_reg))
        |=> (data_out[15] == !$past(out_reg[17])))
        else $error("twos complement msb not inverted");

    serial_float_a: assert property (serial |=>
        (data_oe_out == WORD_RST))
        else $error("parallel bus driven in serial mode");

    msb_first_a: assert property ((act_reg && lvl_reg &&
        div_reg == half - 8'h01 && !reset_in && !pin_fall)
        |=> (sh_reg == {$past(sh_reg[16:0]), 1'b0}))
        else $error("serial word not shifted msb first");

    frame_pol_a: assert property (##1
        (frame_out == $past(act_reg ^ cfg.frm_inv)))
        else $error("frame polarity wrong");

    busy_hold_a: assert property (master_rac_end |=> send_then_busy)
        else $error("busy dropped before serial word sent");

    word_load_a: assert property (!$stable(out_reg) |->
        $past(pop || pin_fall))
        else $error("result changed outside conversion end");

    overrun_pulse_a: assert property (ovr_reg |=>
        (read_overrun_flag_out && !ovr_reg))
        else $error("read error not a single pulse");

endmodule // arh_port

//--- inc/arh_pkg.sv
package arh_pkg;

    localparam int RESULT_W = 18;

    // Interface select codes
    localparam logic [1:0] ARH_MODE_P18 = 2'h0;
    localparam logic [1:0] ARH_MODE_P16 = 2'h1;
    localparam logic [1:0] ARH_MODE_P8  = 2'h2;
    localparam logic [1:0] ARH_MODE_SER = 2'h3;

    // Conversion timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int CONV_TIME_NS  = 1400;
    localparam int CONV_CYCLES   =
        (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [15:0] CONV_LAST = 16'(CONV_CYCLES - 1);

    // Serial clock half periods in system clock cycles, and serial bit counts
    localparam logic [7:0] FAST_HALF = 8'h01;
    localparam logic [7:0] SLOW_HALF = 8'h02;
    localparam logic [7:0] BASE_HALF = 8'h01;
    localparam logic [4:0] FAST_BITS = 5'h0e;
    localparam logic [4:0] LAST_BIT  = 5'h11;
    localparam logic [4:0] ALL_BITS  = 5'h12;

    // Reset values
    localparam logic [17:0] WORD_RST = 18'h00000;
    localparam logic [15:0] CNT_RST  = 16'h0000;
    localparam logic [7:0]  DIV_RST  = 8'h00;
    localparam logic [4:0]  BITS_RST = 5'h00;

    typedef enum logic [2:0] {
        ARH_IDLE = 3'b001,
        ARH_CONV = 3'b010,
        ARH_SEND = 3'b100
    } arh_state_e;

    typedef struct packed {
        logic [1:0] mode;
        logic       coding;
        logic       ext_clk;
        logic       clk_inv;
        logic       frm_inv;
        logic       read_during_convert;
        logic [1:0] div;
    } arh_cfg_s;

endpackage
